// ---- audio_aux_pkg.sv ----
`default_nettype none
package audio_aux_pkg;

  // ==========================================================================
  // Register map
  // ==========================================================================
  // Printed offsets are not all word aligned, so they are indices and the
  // byte address is four times the index.
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] IDX_DMA_SELECT = 12'h0a0;
  localparam logic [ADDR_W-1:0] IDX_ENC_STATUS = 12'h0a1;
  localparam logic [ADDR_W-1:0] IDX_PHASE_CFG = 12'h0a3;
  localparam logic [ADDR_W-1:0] IDX_TRIM = 12'h0a6;
  localparam logic [ADDR_W-1:0] IDX_FREQ = 12'h0a8;
  localparam logic [ADDR_W-1:0] ADDR_DMA_SELECT = IDX_DMA_SELECT << 2;
  localparam logic [ADDR_W-1:0] ADDR_ENC_STATUS = IDX_ENC_STATUS << 2;
  localparam logic [ADDR_W-1:0] ADDR_PHASE_CFG = IDX_PHASE_CFG << 2;
  localparam logic [ADDR_W-1:0] ADDR_TRIM = IDX_TRIM << 2;
  localparam logic [ADDR_W-1:0] ADDR_FREQ = IDX_FREQ << 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ==========================================================================
  // Fields and reset values
  // ==========================================================================
  localparam logic [1:0] DMA_SELECT_RESET = 2'h0;
  localparam logic [5:0] PHASE_CFG_RESET = 6'h00;
  localparam logic [15:0] TRIM_RESET = 16'h8000;
  localparam int SRC_LSB = 0;
  localparam int GAIN_LSB = 3;
  localparam int FLAG_BLOCK_START = 0;
  localparam int FLAG_SYNC_MISSING = 1;
  localparam int FLAG_LENGTH_ERROR = 2;

  localparam logic [2:0] SRC_SERIAL_FIRST = 3'h0;
  localparam logic [2:0] SRC_SERIAL_SECOND = 3'h1;
  localparam logic [2:0] SRC_SERIAL_THIRD = 3'h2;
  localparam logic [2:0] SRC_DIGITAL_AUDIO = 3'h4;

  // ==========================================================================
  // Timing and arithmetic
  // ==========================================================================
  localparam int BLOCK_BYTES = 2352;
  localparam logic [9:0] BLOCK_WORDS = 10'(BLOCK_BYTES / 4);
  localparam logic [3:0] TRIM_DIV_LAST = 4'hf;
  localparam int FILTER_W = 48;
  localparam int RESULT_DROP = 16;
  // Pole shift 15 puts each stage near 80 Hz for a reference of about 17 MHz
  localparam int FILTER_SHIFT = 15;

endpackage
`default_nettype wire

// ---- audio_aux.sv ----
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Block start flag when encoder starts a block
// - Sync missing when block start had no sync
// - Length error when previous block not 2352 bytes
// - Only decoder input, encoder output request DMA
// - Request one: select bit1 chooses full or empty
// - Request zero: select bit0 chooses full or empty
// - Source field picks measured clock
// - Two cascaded registers XORed give edge pulses
// - Digital audio input pulses bypass edge detector
// - Second-order low-pass near 80 Hz, reference clocked
// - Filter 48 bits, drop 16 low bits
// - Result is 32-bit unsigned, software readable
// - Serial clock result is twice rate times gain
// - Digital audio result is rate times gain
// - Gain select field bits 5 to 3
// - Trim duty cycle proportional to trim value
// - Modulator advances once per sixteen system clocks
// - Decoder and encoder ports work independently
// - New block assumed 2352 bytes after previous

module audio_aux (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [11:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic decoder_input_full,
  input wire logic encoder_output_empty,
  input wire logic encoder_word_sent,
  input wire logic encoder_sync_found,
  output logic dma_request_zero,
  output logic dma_request_one,
  input wire logic audio_reference_clock,
  input wire logic serial_bit_clock_first,
  input wire logic serial_bit_clock_second,
  input wire logic serial_bit_clock_third,
  input wire logic digital_audio_input,
  output logic crystal_trim_output
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef struct packed {
    logic awready;
    logic aw_held;
    logic [11:0] aw_addr;
    logic wready;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [1:0] dma_select;
    logic [5:0] phase_cfg;
    logic [15:0] trim_value;
    logic [3:0] trim_div;
    logic [15:0] trim_acc;
    logic trim_out;
    logic dma_zero;
    logic dma_one;
    logic [4:0] sync_a;
    logic [4:0] sync_b;
    logic ref_prev;
    logic edge_a;
    logic edge_b;
    logic [47:0] stage_one;
    logic [47:0] stage_two;
    logic [31:0] result;
    logic [9:0] word_count;
    logic block_seen;
    logic [2:0] flags;
  } state_type;

  state_type state_reg;
  state_type state_next;

  function automatic logic [47:0] gain_of(input logic [2:0] sel);
    logic [47:0] g;
    g = 48'h0;
    unique case (sel)
      3'h0: g = 48'h000000030000;
      3'h1: g = 48'h000000020000;
      3'h2: g = 48'h000000018000;
      3'h3: g = 48'h000000010000;
      3'h4: g = 48'h00000000c000;
      3'h5: g = 48'h000000008000;
      3'h6: g = 48'h000000006000;
      default: g = 48'h0;
    endcase
    return g;
  endfunction

  logic ref_tick;
  logic selected_clock;
  logic edge_pulse;
  logic [47:0] increment;
  logic do_write;
  logic new_block;
  logic by_sync;
  logic [2:0] flag_set;
  logic [2:0] flag_clear;
  logic [2:0] source;

  // ==========================================================================
  // Next state
  // ==========================================================================
  always_comb begin
    state_next = state_reg;
    flag_set = 3'h0;
    flag_clear = 3'h0;
    source = state_reg.phase_cfg[audio_aux_pkg::SRC_LSB +: 3];

    // Pin synchroniser: first stage feeds only the second
    state_next.sync_a = {audio_reference_clock, digital_audio_input,
      serial_bit_clock_third, serial_bit_clock_second, serial_bit_clock_first};
    state_next.sync_b = state_reg.sync_a;
    state_next.ref_prev = state_reg.sync_b[4];
    ref_tick = state_reg.sync_b[4] && !state_reg.ref_prev;

    // Reserved source codes fall back to the first serial clock
    unique case (source)
      audio_aux_pkg::SRC_SERIAL_SECOND: selected_clock = state_reg.sync_b[1];
      audio_aux_pkg::SRC_SERIAL_THIRD: selected_clock = state_reg.sync_b[2];
      default: selected_clock = state_reg.sync_b[0];
    endcase
    if (ref_tick) begin
      state_next.edge_a = selected_clock;
      state_next.edge_b = state_reg.edge_a;
    end
    if (source == audio_aux_pkg::SRC_DIGITAL_AUDIO) begin
      edge_pulse = state_reg.sync_b[3];
    end else begin
      edge_pulse = state_reg.edge_a ^ state_reg.edge_b;
    end

    // Two leaky integrators in cascade; steady state equals pulse rate times
    // gain scaled up by the dropped bits, so the top word is rate times gain
    // Limitation: after a source or gain change the result needs about 2^16 ticks to settle
    increment = edge_pulse ? (gain_of(state_reg.phase_cfg[audio_aux_pkg::GAIN_LSB +: 3]) << 1)
      : 48'h0;
    if (ref_tick) begin
      state_next.stage_one = state_reg.stage_one + increment
        - (state_reg.stage_one >> audio_aux_pkg::FILTER_SHIFT);
      state_next.stage_two = state_reg.stage_two
        + (state_reg.stage_one >> audio_aux_pkg::FILTER_SHIFT)
        - (state_reg.stage_two >> audio_aux_pkg::FILTER_SHIFT);
    end
    state_next.result = state_reg.stage_two[47:audio_aux_pkg::RESULT_DROP];

    // DMA requests follow the FIFO levels with one register delay
    state_next.dma_zero = state_reg.dma_select[0] ? encoder_output_empty
      : decoder_input_full;
    state_next.dma_one = state_reg.dma_select[1] ? encoder_output_empty
      : decoder_input_full;

    // Encoder block tracking, independent of the decoder side
    by_sync = encoder_word_sent && encoder_sync_found;
    new_block = by_sync || (encoder_word_sent
      && state_reg.word_count == audio_aux_pkg::BLOCK_WORDS);
    if (new_block) begin
      flag_set[audio_aux_pkg::FLAG_BLOCK_START] = 1'b1;
      flag_set[audio_aux_pkg::FLAG_SYNC_MISSING] = !by_sync;
      flag_set[audio_aux_pkg::FLAG_LENGTH_ERROR] = state_reg.block_seen
        && state_reg.word_count != audio_aux_pkg::BLOCK_WORDS;
      state_next.word_count = 10'h1;
      state_next.block_seen = 1'b1;
    end else if (encoder_word_sent && state_reg.block_seen) begin
      state_next.word_count = state_reg.word_count + 10'h1;
    end

    // Trim modulator
    // The carry is registered, so the pin holds each decision for 16 cycles
    state_next.trim_div = state_reg.trim_div + 4'h1;
    if (state_reg.trim_div == audio_aux_pkg::TRIM_DIV_LAST) begin
      {state_next.trim_out, state_next.trim_acc} =
        {1'b0, state_reg.trim_acc} + {1'b0, state_reg.trim_value};
    end

    // AXI write channel
    // Address and data latch separately, so either may arrive first
    if (awvalid && state_reg.awready) begin
      state_next.aw_held = 1'b1;
      state_next.aw_addr = awaddr;
    end
    if (wvalid && state_reg.wready) begin
      state_next.w_held = 1'b1;
      state_next.w_data = wdata;
      state_next.w_strb = wstrb;
    end
    if (state_reg.bvalid && bready) begin
      state_next.bvalid = 1'b0;
    end
    do_write = state_reg.aw_held && state_reg.w_held && !state_reg.bvalid;
    if (do_write) begin
      state_next.aw_held = 1'b0;
      state_next.w_held = 1'b0;
      state_next.bvalid = 1'b1;
      state_next.bresp = audio_aux_pkg::RESP_OKAY;
      unique case (state_reg.aw_addr)
        audio_aux_pkg::ADDR_DMA_SELECT: begin
          if (state_reg.w_strb[0]) begin
            state_next.dma_select = state_reg.w_data[1:0];
          end
        end
        audio_aux_pkg::ADDR_ENC_STATUS: begin
          if (state_reg.w_strb[0]) begin
            flag_clear = state_reg.w_data[2:0];
          end
        end
        audio_aux_pkg::ADDR_PHASE_CFG: begin
          if (state_reg.w_strb[0]) begin
            state_next.phase_cfg = state_reg.w_data[5:0];
          end
        end
        audio_aux_pkg::ADDR_TRIM: begin
          // Lanes without a strobe keep their byte
          if (state_reg.w_strb[0]) begin
            state_next.trim_value[7:0] = state_reg.w_data[7:0];
          end
          if (state_reg.w_strb[1]) begin
            state_next.trim_value[15:8] = state_reg.w_data[15:8];
          end
        end
        audio_aux_pkg::ADDR_FREQ: begin
          state_next.bresp = audio_aux_pkg::RESP_SLVERR;
        end
        default: begin
          state_next.bresp = audio_aux_pkg::RESP_SLVERR;
        end
      endcase
    end
    // A flag raised in the clearing cycle survives
    state_next.flags = (state_reg.flags & ~flag_clear) | flag_set;
    state_next.awready = !state_next.aw_held && !state_next.bvalid;
    state_next.wready = !state_next.w_held && !state_next.bvalid;

    // AXI read channel
    // Read data is captured at the address handshake, not at the data handshake
    if (state_reg.rvalid && rready) begin
      state_next.rvalid = 1'b0;
    end
    if (arvalid && state_reg.arready) begin
      state_next.rvalid = 1'b1;
      state_next.rresp = audio_aux_pkg::RESP_OKAY;
      unique case (araddr)
        audio_aux_pkg::ADDR_DMA_SELECT: state_next.rdata = {30'h0, state_reg.dma_select};
        audio_aux_pkg::ADDR_ENC_STATUS: state_next.rdata = {29'h0, state_reg.flags};
        audio_aux_pkg::ADDR_PHASE_CFG: state_next.rdata = {26'h0, state_reg.phase_cfg};
        audio_aux_pkg::ADDR_TRIM: state_next.rdata = {16'h0, state_reg.trim_value};
        audio_aux_pkg::ADDR_FREQ: state_next.rdata = state_reg.result;
        default: begin
          state_next.rdata = 32'h0;
          state_next.rresp = audio_aux_pkg::RESP_SLVERR;
        end
      endcase
    end
    state_next.arready = !state_next.rvalid;
  end

  // ==========================================================================
  // Registers
  // ==========================================================================
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
      // Register fields reload their reset values after the blanket clear; only trim_value is non-zero
      state_reg.dma_select <= audio_aux_pkg::DMA_SELECT_RESET;
      state_reg.phase_cfg <= audio_aux_pkg::PHASE_CFG_RESET;
      state_reg.trim_value <= audio_aux_pkg::TRIM_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  assign awready = state_reg.awready;
  assign wready = state_reg.wready;
  assign bvalid = state_reg.bvalid;
  assign bresp = state_reg.bresp;
  assign arready = state_reg.arready;
  assign rvalid = state_reg.rvalid;
  assign rdata = state_reg.rdata;
  assign rresp = state_reg.rresp;
  assign dma_request_zero = state_reg.dma_zero;
  assign dma_request_one = state_reg.dma_one;
  assign crystal_trim_output = state_reg.trim_out;

  // ==========================================================================
  // Assertions
  // ==========================================================================
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_dma_zero_select: assert property (
    (!state_reg.dma_select[0] && decoder_input_full)[*2] |-> dma_request_zero)
    else $error("request zero missing while decoder input full");
  a_dma_one_select: assert property (
    (state_reg.dma_select[1] && !encoder_output_empty)[*2] |-> !dma_request_one)
    else $error("request one held after encoder output refilled");
  a_trim_divided: assert property (
    $changed(crystal_trim_output) |-> $past(state_reg.trim_div) == 4'hf)
    else $error("trim pin changed off the divided tick");
  a_trim_half: assert property (
    state_reg.trim_value == 16'h8000 && state_reg.trim_acc == 16'h0
      && state_reg.trim_div == 4'hf |=> !crystal_trim_output ##16 crystal_trim_output)
    else $error("half trim value did not alternate");
  a_block_start_set: assert property (
    encoder_word_sent && encoder_sync_found |=> state_reg.flags[0])
    else $error("block start flag not raised");
  a_sync_missing_set: assert property (
    encoder_word_sent && !encoder_sync_found && state_reg.word_count == audio_aux_pkg::BLOCK_WORDS
      |=> state_reg.flags[1] && state_reg.word_count == 10'h1)
    else $error("counted block start did not flag missing sync");
  a_length_error_set: assert property (
    by_sync && state_reg.block_seen && state_reg.word_count != audio_aux_pkg::BLOCK_WORDS
      |=> state_reg.flags[2])
    else $error("short block not flagged");
  a_length_ok: assert property (
    by_sync && state_reg.word_count == audio_aux_pkg::BLOCK_WORDS && !state_reg.flags[2]
      |=> !state_reg.flags[2])
    else $error("length error on nominal block");
  a_filter_hold: assert property (
    !ref_tick |=> $stable(state_reg.stage_one) && $stable(state_reg.stage_two))
    else $error("filter moved without a reference edge");
  a_result_read: assert property (
    arvalid && arready && araddr == 12'h2a0 |=> rvalid && rdata == $past(state_reg.result))
    else $error("frequency result not returned");
  a_bresp_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before acceptance");

  a_dma_zero_empty: assert property (
    (state_reg.dma_select[0] && encoder_output_empty)[*2] |-> dma_request_zero)
    else $error("request zero missing while encoder output empty");
  a_dma_one_full: assert property (
    (!state_reg.dma_select[1] && decoder_input_full)[*2] |-> dma_request_one)
    else $error("request one missing while decoder input full");
  a_edge_shift: assert property (
    ref_tick |=> state_reg.edge_b == $past(state_reg.edge_a))
    else $error("edge detector did not shift on a reference edge");
  a_result_drop: assert property (
    state_reg.result == $past(state_reg.stage_two[47:audio_aux_pkg::RESULT_DROP]))
    else $error("result is not the filter top word");


  c_dma_from_encoder: cover property (state_reg.dma_select == 2'h3 && dma_request_zero);
  c_sync_block: cover property (by_sync ##[1:700] by_sync);
  c_counted_block: cover property (new_block && !by_sync);
  c_trim_high: cover property (crystal_trim_output);
  c_digital_source: cover property (ref_tick
    && state_reg.phase_cfg[2:0] == audio_aux_pkg::SRC_DIGITAL_AUDIO);

endmodule // audio_aux
`default_nettype wire

// ---- dma_partner.sv ----
`timescale 1ns/1ps
`default_nettype none
module dma_partner (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic dma_request_zero,
  input wire logic dma_request_one,
  input wire logic route_zero,
  input wire logic route_one,
  input wire logic set_full,
  input wire logic set_empty,
  input wire logic [3:0] lag,
  output logic decoder_input_full,
  output logic encoder_output_empty
);
  // Only the two single-word ports are modelled, served through one shared lag counter
  typedef struct packed {logic full; logic empty; logic [3:0] cnt;} partner_state_type;
  partner_state_type state_reg;
  partner_state_type state_next;
  logic any_req;
  logic serve;
  always_comb begin
    state_next = state_reg;
    any_req = dma_request_zero || dma_request_one;
    serve = any_req && (state_reg.cnt == lag);
    state_next.cnt = (any_req && !serve) ? state_reg.cnt + 4'h1 : 4'h0;
    // A channel moves one word per service, to whichever port its request is routed from
    if (serve && ((dma_request_zero && route_zero) || (dma_request_one && route_one))) begin
      state_next.empty = 1'b0;
    end
    if (serve && ((dma_request_zero && !route_zero) || (dma_request_one && !route_one))) begin
      state_next.full = 1'b0;
    end
    if (set_full) begin
      state_next.full = 1'b1;
    end
    if (set_empty) begin
      state_next.empty = 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end
  assign decoder_input_full = state_reg.full;
  assign encoder_output_empty = state_reg.empty;
endmodule // dma_partner
`default_nettype wire

// ---- audio_aux_dma_frequency_measure_result_trim_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module audio_aux_dma_frequency_measure_result_trim_tb_top;
  logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, set_full, set_empty, route_zero, route_one;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, base_result;
  logic [3:0] wstrb, lag;
  logic [1:0] bresp, rresp;
  logic decoder_input_full, encoder_output_empty, encoder_word_sent, encoder_sync_found;
  logic dma_request_zero, dma_request_one, audio_reference_clock, digital_audio_input;
  logic serial_bit_clock_first, serial_bit_clock_second, serial_bit_clock_third;
  logic crystal_trim_output;
  int n_errors, n_compared;
  audio_aux dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
    .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
    .rready, .decoder_input_full, .encoder_output_empty, .encoder_word_sent,
    .encoder_sync_found, .dma_request_zero, .dma_request_one, .audio_reference_clock,
    .serial_bit_clock_first, .serial_bit_clock_second, .serial_bit_clock_third,
    .digital_audio_input, .crystal_trim_output);
  dma_partner partner (.aclk, .aresetn, .dma_request_zero, .dma_request_one, .route_zero,
    .route_one, .set_full, .set_empty, .lag, .decoder_input_full, .encoder_output_empty);
  // ==========================================================================
  // Clocks: the reference is offset so it never lines up with aclk
  // ==========================================================================
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  initial begin
    audio_reference_clock = 1'b0;
    #3;
    forever #32 audio_reference_clock = ~audio_reference_clock;
  end
  initial begin
    serial_bit_clock_first = 1'b0;
    forever #128 serial_bit_clock_first = ~serial_bit_clock_first;
  end
  initial begin
    serial_bit_clock_second = 1'b0;
    forever #256 serial_bit_clock_second = ~serial_bit_clock_second;
  end
  initial begin
    serial_bit_clock_third = 1'b0;
    forever #512 serial_bit_clock_third = ~serial_bit_clock_third;
  end
  // ==========================================================================
  // Checking and bus tasks
  // ==========================================================================
  task automatic complete_run();
    $display("Errors %0d, compared %0d", n_errors, n_compared);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic check_near(input logic [31:0] got, input longint exp, input longint tol);
    longint d;
    n_compared++;
    d = longint'(got) - exp;
    if ((^got) === 1'bx || d > tol || d < -tol) begin
      n_errors++;
      $display("[ERR] %0t got %0d expected about %0d", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic [1:0] exp_resp);
    bit aw_done, w_done;
    @(posedge aclk);
    awaddr <= a; wdata <= d; wstrb <= s; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    aw_done = 0; w_done = 0;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (!aw_done && awready === 1'b1) begin aw_done = 1; awvalid <= 1'b0; end
      if (!w_done && wready === 1'b1) begin w_done = 1; wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check_val({30'h0, bresp}, {30'h0, exp_resp});
  endtask
  task automatic axi_read(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata; r = rresp; rready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic [1:0] exp_resp);
    logic [31:0] d;
    logic [1:0] r;
    axi_read(a, d, r);
    check_val(d, exp);
    check_val({30'h0, r}, {30'h0, exp_resp});
  endtask
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  task automatic reset_values();
    rd(audio_aux_pkg::ADDR_DMA_SELECT, 32'h0, 2'h0);
    rd(audio_aux_pkg::ADDR_TRIM, 32'h8000, 2'h0);
    rd(audio_aux_pkg::ADDR_ENC_STATUS, 32'h0, 2'h0);
    wr(audio_aux_pkg::ADDR_FREQ, 32'hffffffff, 4'hf, 2'h2);
    rd(audio_aux_pkg::ADDR_FREQ, 32'h0, 2'h0);
    rd(12'h004, 32'h0, 2'h2);
    wr(audio_aux_pkg::ADDR_PHASE_CFG, 32'hff, 4'h1, 2'h0);
    rd(audio_aux_pkg::ADDR_PHASE_CFG, 32'h3f, 2'h0);
  endtask
  task automatic dma_routes();
    logic [1:0] sel;
    for (int i = 0; i < 4; i++) begin
      sel = 2'(i);
      do_reset();
      wr(audio_aux_pkg::ADDR_DMA_SELECT, {30'h0, sel}, 4'h1, 2'h0);
      rd(audio_aux_pkg::ADDR_DMA_SELECT, {30'h0, sel}, 2'h0);
      route_zero <= sel[0]; route_one <= sel[1]; lag <= 4'h8; set_full <= 1'b1;
      @(posedge aclk);
      set_full <= 1'b0;
      repeat (3) @(posedge aclk);
      check_val({30'h0, dma_request_one, dma_request_zero}, {30'h0, ~sel});
      repeat (16) @(posedge aclk);
      check_val({30'h0, dma_request_one, dma_request_zero}, 32'h0);
      lag <= 4'h1; set_empty <= 1'b1;
      @(posedge aclk);
      set_empty <= 1'b0;
      repeat (3) @(posedge aclk);
      check_val({30'h0, dma_request_one, dma_request_zero}, {30'h0, sel});
      repeat (8) @(posedge aclk);
      check_val({30'h0, dma_request_one, dma_request_zero}, 32'h0);
    end
  endtask
  task automatic send_words(input int n, input logic sync);
    @(posedge aclk);
    encoder_word_sent <= 1'b1; encoder_sync_found <= sync;
    repeat (n) begin @(posedge aclk); encoder_sync_found <= 1'b0; end
    encoder_word_sent <= 1'b0;
  endtask
  task automatic clear_flags();
    wr(audio_aux_pkg::ADDR_ENC_STATUS, 32'h7, 4'h1, 2'h0);
    rd(audio_aux_pkg::ADDR_ENC_STATUS, 32'h0, 2'h0);
  endtask
  task automatic enc_flags();
    send_words(1, 1'b1);
    rd(audio_aux_pkg::ADDR_ENC_STATUS, 32'h1, 2'h0);
    clear_flags();
    send_words(587, 1'b0);
    rd(audio_aux_pkg::ADDR_ENC_STATUS, 32'h0, 2'h0);
    send_words(1, 1'b0);
    rd(audio_aux_pkg::ADDR_ENC_STATUS, 32'h3, 2'h0);
    clear_flags();
    send_words(9, 1'b0);
    send_words(1, 1'b1);
    rd(audio_aux_pkg::ADDR_ENC_STATUS, 32'h5, 2'h0);
    clear_flags();
  endtask
  task automatic trim_duty(input logic [15:0] v);
    int hi;
    wr(audio_aux_pkg::ADDR_TRIM, {16'h0, v}, 4'h3, 2'h0);
    repeat (32) @(posedge aclk);
    hi = 0;
    repeat (1024) begin @(posedge aclk); if (crystal_trim_output === 1'b1) hi++; end
    // A divided tick and a half of slack, since the window is not aligned to the divider
    check_near(32'(hi), (longint'(v) * 1024) / 65536, 24);
  endtask
  task automatic freq_case(input logic [2:0] src, input logic [2:0] gain, input int num,
      input int den);
    logic [31:0] got;
    logic [1:0] r;
    do_reset();
    digital_audio_input <= (src == audio_aux_pkg::SRC_DIGITAL_AUDIO);
    wr(audio_aux_pkg::ADDR_PHASE_CFG, {26'h0, gain, src}, 4'h1, 2'h0);
    // About 1750 reference ticks: the rise is still quadratic, far from settling
    repeat (14000) @(posedge aclk);
    axi_read(audio_aux_pkg::ADDR_FREQ, got, r);
    if (num == 0) begin
      base_result = got;
      check_val({31'h0, got > 32'h40}, 32'h1);
    end else begin
      // Early in the rise the output scales with input rate and gain
      check_near(got, longint'(base_result) * num / den,
        longint'(base_result) / 16);
    end
  endtask
  initial begin
    #780000;
    n_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    complete_run();
  end
  initial begin
    n_errors = 0; n_compared = 0; base_result = 32'h0; aresetn = 1'b0;
    awaddr = 12'h0; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'h0; wvalid = 1'b0; bready = 1'b0;
    araddr = 12'h0; arvalid = 1'b0; rready = 1'b0; set_full = 1'b0; set_empty = 1'b0;
    route_zero = 1'b0; route_one = 1'b0; lag = 4'h1; encoder_word_sent = 1'b0;
    encoder_sync_found = 1'b0; digital_audio_input = 1'b0;
    do_reset();
    reset_values();
    dma_routes();
    enc_flags();
    trim_duty(16'h0000);
    trim_duty(16'h8000);
    trim_duty(16'hffff);
    trim_duty(16'h4000);
    freq_case(audio_aux_pkg::SRC_SERIAL_FIRST, 3'h0, 0, 1);
    freq_case(audio_aux_pkg::SRC_SERIAL_SECOND, 3'h0, 1, 2);
    freq_case(audio_aux_pkg::SRC_SERIAL_THIRD, 3'h0, 1, 4);
    freq_case(audio_aux_pkg::SRC_DIGITAL_AUDIO, 3'h0, 2, 1);
    freq_case(audio_aux_pkg::SRC_SERIAL_FIRST, 3'h1, 2, 3);
    freq_case(audio_aux_pkg::SRC_SERIAL_FIRST, 3'h6, 1, 8);
    complete_run();
  end
endmodule // audio_aux_dma_frequency_measure_result_trim_tb_top
`default_nettype wire
